// ==== rtl/adc_data_port.sv ====
/*
 * Converter data port: takes inverted 16-bit results from an external
 * converter over an active-low handshake and counts them into a small
 * histogram, in plain or loss-free mode, with a live-time counter.
 * Assumes all port inputs are synchronous to mclk_i and that the
 * register master keeps the plain strobe protocol.
 */
// How it works
// - Names ending _n are active low.
// - Take inverted 16-bit word, bit0 is LSB.
// - Drive buffer enable low to fetch data.
// - Pull data-accepted low once word taken.
// - Inhibit discards word outside loss-free first state.
// - Loss-free first state inhibit: word is increment.
// - Plain mode adds one to addressed bin.
// - Loss-free mode adds received increment to bin.
// - Converter-enable low lets converter run.
// - Dead-time input gates live-time counting.
`default_nettype none

module adc_data_port (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [12:0] conv_data_lo_n_i,
    input wire logic conv_data_bit13_n_i,
    input wire logic [1:0] conv_data_hi_n_i,
    input wire logic word_available_n_i,
    input wire logic inhibit_n_i,
    input wire logic composite_dead_time_n_i,
    output logic data_output_enable_n_o,
    output logic data_accepted_n_o,
    output logic converter_enable_n_o,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);

    // ****************************************************************
    // State
    // ****************************************************************

    // Everything the port remembers, registered as one word.
    typedef struct packed {
        conv_port_pkg::xfer_state_e st; // Handshake step.
        logic [7:0] cnt; // Buffer enable cycle count.
        logic [15:0] word; // Word taken, true polarity.
        logic inhib; // Inhibit seen with the word.
        logic phase2; // Loss-free second state pending.
        logic [7:0] incr; // Increment for the next add.
        logic [31:0] rmw; // Bin value read for the add.
        logic [1:0] ctrl; // Enable and mode bits.
        logic [31:0] live; // Live-time cycles.
        logic [31:0] events; // Words counted.
        logic [31:0] discards; // Words discarded.
        logic [31:0] rdata; // Read data for the bus.
        logic [15:0][31:0] hist; // Histogram bins.
    } port_state_s;

    port_state_s state_reg; // Registered state.
    port_state_s state_next; // Next state.
    logic [15:0] pins_word; // Data lines gathered in bit order.
    logic [3:0] bin_idx; // Bin picked by the held word.
    logic [3:0] bus_idx; // Bin picked by the bus address.
    logic hist_hit; // Bus address falls in the histogram.
    logic xfer_done; // Last buffer enable cycle before the word is taken.

    // Bit 13 arrives on its own line; restore weight order here.
    assign pins_word = {conv_data_hi_n_i, conv_data_bit13_n_i,
                        conv_data_lo_n_i};
    assign bin_idx = state_reg.word[3:0];
    assign bus_idx = addr_i[5:2];
    assign hist_hit = (addr_i[11:6] == conv_port_pkg::HIST_OFS[11:6]);
    assign xfer_done = (state_reg.cnt ==
                        8'(conv_port_pkg::XFER_CYC - 1));

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Strobes follow the step; both stay low until the word is withdrawn.
    assign data_output_enable_n_o = !((state_reg.st ==
        conv_port_pkg::ST_ENABLE) || (state_reg.st ==
        conv_port_pkg::ST_ACCEPT));
    assign data_accepted_n_o = !(state_reg.st ==
        conv_port_pkg::ST_ACCEPT);
    assign converter_enable_n_o =
        !state_reg.ctrl[conv_port_pkg::CTRL_EN_BIT];
    assign rdata_o = state_reg.rdata;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Bus access first, so a hardware update in the same cycle wins.
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = 32'h0;
        if (wr_i)
        begin
            if (addr_i == conv_port_pkg::CTRL_OFS)
                state_next.ctrl = wdata_i[1:0];
            else if (addr_i == conv_port_pkg::LIVE_OFS)
                state_next.live = 32'h0;
            else if (hist_hit)
                state_next.hist[bus_idx] = wdata_i;
        end
        if (rd_i)
        begin
            // Unmapped addresses read as zero.
            if (addr_i == conv_port_pkg::CTRL_OFS)
                state_next.rdata = {30'h0, state_reg.ctrl};
            else if (addr_i == conv_port_pkg::STATUS_OFS)
                state_next.rdata = {30'h0, state_reg.phase2,
                    state_reg.st != conv_port_pkg::ST_IDLE};
            else if (addr_i == conv_port_pkg::LIVE_OFS)
                state_next.rdata = state_reg.live;
            else if (addr_i == conv_port_pkg::EVENTS_OFS)
                state_next.rdata = state_reg.events;
            else if (addr_i == conv_port_pkg::DISCARDS_OFS)
                state_next.rdata = state_reg.discards;
            else if (hist_hit)
                state_next.rdata = state_reg.hist[bus_idx];
        end
        // Live time runs only while enabled and out of dead time.
        if (state_reg.ctrl[conv_port_pkg::CTRL_EN_BIT] &&
            composite_dead_time_n_i)
            state_next.live = state_next.live + 32'h1;
        case (state_reg.st)
            conv_port_pkg::ST_IDLE:
            begin
                state_next.cnt = 8'h0;
                // The converter signals a ready word by pulling low.
                if (!word_available_n_i)
                    state_next.st = conv_port_pkg::ST_ENABLE;
            end
            conv_port_pkg::ST_ENABLE:
            begin
                // Hold the buffers open long enough for the cable.
                state_next.cnt = state_reg.cnt + 8'h1;
                if (xfer_done)
                begin
                    state_next.word = ~pins_word;
                    state_next.inhib = !inhibit_n_i;
                    state_next.st = conv_port_pkg::ST_ACCEPT;
                end
            end
            conv_port_pkg::ST_ACCEPT:
            begin
                // Release only after the converter withdraws its word.
                if (word_available_n_i)
                begin
                    state_next.st = conv_port_pkg::ST_IDLE;
                    if (state_reg.ctrl[conv_port_pkg::CTRL_LFC_BIT] &&
                        !state_reg.phase2 && state_reg.inhib)
                    begin
                        // First loss-free state: the word is a count.
                        state_next.incr = state_reg.word[7:0];
                        state_next.phase2 = 1'b1;
                    end
                    else if (state_reg.inhib)
                    begin
                        state_next.discards =
                            state_reg.discards + 32'h1;
                        state_next.phase2 = 1'b0;
                    end
                    else
                    begin
                        if (!(state_reg.ctrl[conv_port_pkg::CTRL_LFC_BIT]
                              && state_reg.phase2))
                            state_next.incr = 8'h1;
                        state_next.phase2 = 1'b0;
                        state_next.st = conv_port_pkg::ST_READ;
                    end
                end
            end
            conv_port_pkg::ST_READ:
            begin
                state_next.rmw = state_next.hist[bin_idx];
                state_next.st = conv_port_pkg::ST_WRITE;
            end
            conv_port_pkg::ST_WRITE:
            begin
                state_next.hist[bin_idx] = state_reg.rmw +
                    {24'h0, state_reg.incr};
                state_next.events = state_reg.events + 32'h1;
                state_next.st = conv_port_pkg::ST_IDLE;
            end
            default:
                state_next.st = conv_port_pkg::ST_IDLE;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset loads constants only.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= '0;
            state_reg.ctrl <= conv_port_pkg::CTRL_RST;
        end
        else
            state_reg <= state_next;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    // Helper: cycles the buffers have been enabled in a row.
    logic [7:0] en_run_reg;
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            en_run_reg <= 8'h0;
        else if (data_output_enable_n_o)
            en_run_reg <= 8'h0;
        else if (en_run_reg != 8'hFF)
            en_run_reg <= en_run_reg + 8'h1;
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence rmw_seq;
        state_reg.st == conv_port_pkg::ST_WRITE ##1
        state_reg.st == conv_port_pkg::ST_IDLE;
    endsequence

    AST_SETUP: assert property (
        $fell(data_accepted_n_o) |->
        en_run_reg == 8'(conv_port_pkg::XFER_CYC))
        else $error("Word accepted before the buffer enable time.");
    AST_ENABLE_FIRST: assert property (
        $fell(data_accepted_n_o) |-> $past(!data_output_enable_n_o))
        else $error("Accept raised without enabled buffers.");
    AST_WORD: assert property (
        state_reg.st == conv_port_pkg::ST_ENABLE && xfer_done |=>
        state_reg.word == ~$past(pins_word))
        else $error("Taken word does not match inverted lines.");
    AST_HOLD: assert property (
        !data_accepted_n_o && !word_available_n_i |=>
        !data_accepted_n_o && !data_output_enable_n_o)
        else $error("Strobes released while word still offered.");
    AST_RELEASE: assert property (
        !data_accepted_n_o && word_available_n_i |=>
        data_accepted_n_o && data_output_enable_n_o)
        else $error("Strobes not released after withdrawal.");
    AST_CONV_EN: assert property (
        wr_i && addr_i == conv_port_pkg::CTRL_OFS |=>
        converter_enable_n_o == !$past(wdata_i[0]))
        else $error("Converter enable does not follow control.");
    AST_DISCARD: assert property (
        state_reg.st == conv_port_pkg::ST_ACCEPT && state_reg.inhib &&
        !(state_reg.ctrl[1] && !state_reg.phase2) && word_available_n_i
        |=> state_reg.st == conv_port_pkg::ST_IDLE &&
        state_reg.discards == $past(state_reg.discards) + 32'h1)
        else $error("Inhibited word was not discarded.");
    AST_LFC_COUNT: assert property (
        state_reg.st == conv_port_pkg::ST_ACCEPT && state_reg.inhib &&
        state_reg.ctrl[1] && !state_reg.phase2 && word_available_n_i
        |=> state_reg.phase2 && state_reg.incr == $past(state_reg.word[7:0]))
        else $error("Loss-free increment not captured.");
    AST_PHA_ONE: assert property (
        state_reg.st == conv_port_pkg::ST_READ && !state_reg.ctrl[1] |->
        state_reg.incr == 8'h1)
        else $error("Plain mode increment is not one.");
    AST_ADD: assert property (
        state_reg.st == conv_port_pkg::ST_WRITE &&
        !(wr_i && hist_hit && bus_idx == bin_idx) |=>
        state_reg.hist[$past(bin_idx)] ==
        $past(state_reg.rmw) + {24'h0, $past(state_reg.incr)})
        else $error("Bin not updated by the increment.");
    AST_ONE_WORD: assert property (
        state_reg.st == conv_port_pkg::ST_READ |=> rmw_seq)
        else $error("Bin update did not finish before the next word.");
    AST_LIVE: assert property (
        !composite_dead_time_n_i &&
        !(wr_i && addr_i == conv_port_pkg::LIVE_OFS) |=>
        $stable(state_reg.live))
        else $error("Live time counted during dead time.");

endmodule

`default_nettype wire

// ==== rtl/conv_port_pkg.sv ====
/*
 * Shared constants for the converter data port: register offsets, field
 * positions, reset values, the handshake timing and the transfer states.
 * Assumes a single 100 MHz system clock and a byte-addressed register port.
 */
`default_nettype none

package conv_port_pkg;

    // ****************************************************************
    // Clock and transfer timing
    // ****************************************************************

    // System clock period in picoseconds.
    localparam int CLK_PERIOD_PS = 10000;
    // Least time the data buffers are enabled before the word is taken.
    localparam int XFER_TIME_NS = 1000;
    // Cycles of buffer enable before sampling, rounded up.
    localparam int XFER_CYC = (XFER_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;

    // ****************************************************************
    // Widths and histogram shape
    // ****************************************************************

    // Width of a converter word.
    localparam int WORD_W = 16;
    // Width of a histogram count and of the register data.
    localparam int DATA_W = 32;
    // Width of the register address.
    localparam int ADDR_W = 12;
    // Number of histogram bins held in flip-flops.
    localparam int BINS = 16;
    // Bits of the channel number that pick a bin.
    localparam int BIN_W = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************

    // Control: converter enable and loss-free counting mode.
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    // Status: transfer busy and loss-free second state pending.
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
    // Live-time cycle count; any write clears it.
    localparam logic [ADDR_W-1:0] LIVE_OFS = 12'h008;
    // Count of words added to the histogram.
    localparam logic [ADDR_W-1:0] EVENTS_OFS = 12'h00C;
    // Count of words thrown away under inhibit.
    localparam logic [ADDR_W-1:0] DISCARDS_OFS = 12'h010;
    // First histogram bin; bins follow one word apart.
    localparam logic [ADDR_W-1:0] HIST_OFS = 12'h100;

    // Control field positions.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LFC_BIT = 1;
    // Status field positions.
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PHASE2_BIT = 1;
    // Control value after reset: converter disabled, plain counting.
    localparam logic [1:0] CTRL_RST = 2'h0;

    // ****************************************************************
    // Transfer states
    // ****************************************************************

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ENABLE,
        ST_ACCEPT,
        ST_READ,
        ST_WRITE
    } xfer_state_e;

endpackage

`default_nettype wire

// ==== test/conv_model.sv ====
/*
 * Behavioural converter for the data port bench: offers one word with an
 * optional inhibit, holds word-available low for a chosen number of
 * cycles after acceptance, and flags a port that lets go too early.
 * Assumes the bench drives go_i, word_i, inh_i and hold_i on mclk_i.
 */
`default_nettype none

module conv_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic [15:0] word_i,
    input wire logic inh_i,
    input wire logic [3:0] hold_i,
    input wire logic enable_n_i,
    input wire logic accepted_n_i,
    output logic [12:0] lo_n_o,
    output logic bit13_n_o,
    output logic [1:0] hi_n_o,
    output logic avail_n_o,
    output logic inhibit_n_o,
    output logic done_o,
    output logic early_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] st; // Idle, wait accept, hold, wait release.
    logic [3:0] cnt; // Cycles left before withdrawing the word.

    // The lines have pull-ups, so released buffers read as all ones.
    assign {hi_n_o, bit13_n_o, lo_n_o} =
        enable_n_i ? 16'hFFFF : ~word_i;
    // Inhibit qualifies the offered word only.
    assign inhibit_n_o = ~(inh_i & ~avail_n_o);

    // Four-phase offer towards the bench, handshake towards the port.
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= 2'h0;
            cnt <= 4'h0;
            avail_n_o <= 1'h1;
            done_o <= 1'h0;
            early_o <= 1'h0;
        end
        else if (st == 2'h0)
        begin
            if (!go_i)
                done_o <= 1'h0;
            else if (!done_o)
            begin
                avail_n_o <= 1'h0;
                st <= 2'h1;
            end
        end
        else if (st == 2'h1 && !accepted_n_i)
        begin
            cnt <= hold_i;
            st <= 2'h2;
        end
        else if (st == 2'h2)
        begin
            // Strobes must stay down until the word is withdrawn.
            if (accepted_n_i || enable_n_i)
                early_o <= 1'h1;
            if (cnt == 4'h0)
            begin
                avail_n_o <= 1'h1;
                st <= 2'h3;
            end
            else
                cnt <= cnt - 4'h1;
        end
        else if (st == 2'h3 && accepted_n_i)
        begin
            done_o <= 1'h1;
            st <= 2'h0;
        end
    end
endmodule

`default_nettype wire

// ==== test/test_adc_data_port.sv ====
/*
 * Self-checking bench for the converter data port: table of transfers
 * in plain and loss-free modes, then busy, map, live time and reset cases.
 * Assumes the design and conv_model are compiled before this file.
 */
`default_nettype none

module test_adc_data_port;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic loss_free_counting;
        logic [15:0] word;
        logic inh;
        logic [11:0] addr;
        logic [31:0] exp;
    } row_s;

    logic mclk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic [12:0] lo_n;
    logic bit13_n;
    logic [1:0] hi_n;
    logic avail_n, inh_n, en_n, acc_n, cen_n;
    logic dead_n = 1'h0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [31:0] rdata_o, d;
    logic go = 1'h0;
    logic inh = 1'h0;
    logic [15:0] word = 16'h0;
    logic [3:0] hold = 4'h0;
    logic done, early;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int run = 0;
    int seen = 0;
    // Loss-free increment rows read status: second state pending, idle.
    row_s rows [12] = '{
        '{1'h0, 16'h0003, 1'h0, 12'h10C, 32'h1},
        '{1'h0, 16'hFFF3, 1'h1, 12'h10C, 32'h1},
        '{1'h0, 16'h0003, 1'h0, 12'h10C, 32'h2},
        '{1'h1, 16'h0005, 1'h1, 12'h004, 32'h2},
        '{1'h1, 16'h0007, 1'h0, 12'h11C, 32'h5},
        '{1'h1, 16'h0009, 1'h0, 12'h124, 32'h1},
        '{1'h1, 16'h00FF, 1'h1, 12'h004, 32'h2},
        '{1'h1, 16'h000A, 1'h1, 12'h004, 32'h0},
        '{1'h1, 16'h00FF, 1'h1, 12'h004, 32'h2},
        '{1'h1, 16'h000A, 1'h0, 12'h128, 32'hFF},
        '{1'h0, 16'h800C, 1'h0, 12'h130, 32'h1},
        '{1'h0, 16'h2004, 1'h0, 12'h110, 32'h1}};

    adc_data_port i_adc_data_port (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .conv_data_lo_n_i(lo_n), .conv_data_bit13_n_i(bit13_n),
        .conv_data_hi_n_i(hi_n), .word_available_n_i(avail_n),
        .inhibit_n_i(inh_n), .composite_dead_time_n_i(dead_n),
        .data_output_enable_n_o(en_n), .data_accepted_n_o(acc_n),
        .converter_enable_n_o(cen_n), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

    conv_model i_conv_model (.mclk_i(mclk_i), .nrst_i(nrst_i), .go_i(go),
        .word_i(word), .inh_i(inh), .hold_i(hold), .enable_n_i(en_n),
        .accepted_n_i(acc_n), .lo_n_o(lo_n), .bit13_n_o(bit13_n),
        .hi_n_o(hi_n), .avail_n_o(avail_n), .inhibit_n_o(inh_n),
        .done_o(done), .early_o(early));

    // ****************************************************************
    // Clock, timeout and buffer-enable timing monitor
    // ****************************************************************

    always #5 mclk_i = ~mclk_i;

    // Counts enable cycles before acceptance; keeps the last run length.
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
        if (en_n === 1'h0 && acc_n === 1'h1)
            run <= run + 1;
        else
        begin
            if (run != 0)
                seen <= run;
            run <= 0;
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge mclk_i);
        wr_i <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        #1 v = rdata_o;
    endtask

    // One transfer; three cycles cover the read and write states after.
    task automatic xfer(input logic [15:0] w, input logic i,
                        input logic [3:0] h);
        int n;
        n = 0;
        @(posedge mclk_i);
        word <= w;
        inh <= i;
        hold <= h;
        go <= 1'h1;
        while (done !== 1'h1 && n < 400)
        begin
            @(posedge mclk_i);
            n++;
        end
        go <= 1'h0;
        chk("transfer done", 32'h1, 32'(n < 400));
        repeat (3) @(posedge mclk_i);
    endtask

    // Main sequence: reset, table of transfers, then awkward cases.
    initial
    begin
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'h1;
        #1 chk("strobes idle", 32'h3, {30'h0, en_n, acc_n});
        chk("converter off", 32'h1, 32'(cen_n));
        rd(conv_port_pkg::CTRL_OFS, d);
        chk("ctrl reset", 32'h0, d);
        wr(conv_port_pkg::CTRL_OFS, 32'h1);
        #1 chk("converter on", 32'h0, 32'(cen_n));
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            wr(conv_port_pkg::CTRL_OFS, {30'h0, rows[i].loss_free_counting, 1'h1});
            xfer(rows[i].word, rows[i].inh, 4'(i % 4));
            rd(rows[i].addr, d);
            chk($sformatf("row%0d", i), rows[i].exp, d);
        end
        chk("enable time", conv_port_pkg::XFER_CYC, seen);
        chk("release order", 32'h0, 32'(early));
        $display("test rows done");
        fork
            xfer(16'h0001, 1'h0, 4'h2);
            begin
                repeat (20) @(posedge mclk_i);
                rd(conv_port_pkg::STATUS_OFS, d);
                chk("busy", 32'h1, d);
            end
        join
        rd(conv_port_pkg::EVENTS_OFS, d);
        chk("events", 32'h8, d);
        rd(conv_port_pkg::DISCARDS_OFS, d);
        chk("discards", 32'h2, d);
        wr(conv_port_pkg::STATUS_OFS, 32'hFFFFFFFF);
        rd(conv_port_pkg::STATUS_OFS, d);
        chk("status read only", 32'h0, d);
        rd(12'h020, d);
        chk("unmapped", 32'h0, d);
        // Software may preset a bin over the bus.
        wr(conv_port_pkg::HIST_OFS + 12'h4, 32'h7);
        rd(conv_port_pkg::HIST_OFS + 12'h4, d);
        chk("bin write", 32'h7, d);
        $display("test busy and map done");
        wr(conv_port_pkg::LIVE_OFS, 32'h0);
        rd(conv_port_pkg::LIVE_OFS, d);
        chk("live dead", 32'h0, d);
        @(posedge mclk_i);
        dead_n <= 1'h1;
        repeat (20) @(posedge mclk_i);
        dead_n <= 1'h0;
        rd(conv_port_pkg::LIVE_OFS, d);
        chk("live count", 32'd20, d);
        wr(conv_port_pkg::CTRL_OFS, 32'h0);
        dead_n <= 1'h1;
        repeat (10) @(posedge mclk_i);
        dead_n <= 1'h0;
        rd(conv_port_pkg::LIVE_OFS, d);
        chk("live gated", 32'd20, d);
        chk("converter off", 32'h1, 32'(cen_n));
        $display("test live time done");
        // Reset in mid-transfer must drop both strobes and clear state.
        wr(conv_port_pkg::CTRL_OFS, 32'h3);
        @(posedge mclk_i);
        word <= 16'h0002;
        go <= 1'h1;
        repeat (10) @(posedge mclk_i);
        #1 chk("enable mid transfer", 32'h0, 32'(en_n));
        @(posedge mclk_i);
        nrst_i <= 1'h0;
        go <= 1'h0;
        #1 chk("strobes in reset", 32'h3, {30'h0, en_n, acc_n});
        chk("converter off in reset", 32'h1, 32'(cen_n));
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'h1;
        rd(conv_port_pkg::EVENTS_OFS, d);
        chk("events after reset", 32'h0, d);
        rd(conv_port_pkg::CTRL_OFS, d);
        chk("ctrl after reset", 32'h0, d);
        rd(conv_port_pkg::HIST_OFS + 12'hC, d);
        chk("bin after reset", 32'h0, d);
        $display("test mid-run reset done");
        results();
    end
endmodule

`default_nettype wire
